// file: logic/dmapf_defines.vh
`ifndef DMAPF_DEFINES_VH
`define DMAPF_DEFINES_VH

// bus geometry
`define DMAPF_ADDR_W 8
`define DMAPF_DATA_W 32
`define DMAPF_PTR_W 16

// register byte offsets
`define DMAPF_OFS_EVENT 8'h00
`define DMAPF_OFS_MASK 8'h04
`define DMAPF_OFS_CTRL 8'h08
`define DMAPF_OFS_PTRS 8'h0c

// flag positions in event and mask registers
`define DMAPF_BIT_SRC_DONE 7
`define DMAPF_BIT_SRC_HALF 6
`define DMAPF_BIT_DST_DONE 5
`define DMAPF_FLAG_HI 7
`define DMAPF_FLAG_LO 5
`define DMAPF_ZERO_HI 15
`define DMAPF_ZERO_LO 8

// control register fields
`define DMAPF_BIT_ENABLE 0

// reset values
`define DMAPF_RST_FLAGS 3'h0
`define DMAPF_RST_MASK 3'h0
`define DMAPF_RST_ENABLE 1'h0

// axi responses
`define DMAPF_RESP_OKAY 2'h0
`define DMAPF_RESP_SLVERR 2'h2

`endif

// file: logic/dmapf_detect.v
`timescale 1ns/100ps
`default_nettype none
`include "dmapf_defines.vh"

// one-cycle pulse in the cycle after a pointer first becomes equal to its target
module dmapf_detect (
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  input wire arm,
  input wire [`DMAPF_PTR_W-1:0] ptr,
  input wire [`DMAPF_PTR_W-1:0] target,
  output reg hit_r
);

  reg eq_prev_r;
  wire eq_now;

  assign eq_now = (ptr == target);

  // edge, not level: a pointer parked on its target raises the flag once
  always @(posedge aclk) begin
    if (!aresetn) begin
      eq_prev_r <= 1'b0;
      hit_r <= 1'b0;
    end else if (aclken) begin
      eq_prev_r <= eq_now;
      hit_r <= arm & eq_now & ~eq_prev_r;
    end
  end

endmodule // dmapf_detect

`default_nettype wire

// file: logic/dmapf_top.v
// Notes on behaviour
// - bits fifteen down to eight of the event register always read zero.
// - source-done flag, bit seven, sets when source pointer equals source size.
// - source-half flag, bit six, sets when source pointer equals half source size.
// - destination-done flag, bit five, sets when destination pointer equals its size.
`timescale 1ns/100ps
`default_nettype none
`include "dmapf_defines.vh"

module dmapf_top (
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  input wire [`DMAPF_PTR_W-1:0] source_pointer,
  input wire [`DMAPF_PTR_W-1:0] source_size,
  input wire [`DMAPF_PTR_W-1:0] destination_pointer,
  input wire [`DMAPF_PTR_W-1:0] destination_size,
  input wire [`DMAPF_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [`DMAPF_DATA_W-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`DMAPF_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [`DMAPF_DATA_W-1:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq_r
);

  // true for the four word addresses this block answers
  function mapped;
    input [`DMAPF_ADDR_W-1:0] a;
    begin
      mapped = (a == `DMAPF_OFS_EVENT) || (a == `DMAPF_OFS_MASK) ||
               (a == `DMAPF_OFS_CTRL) || (a == `DMAPF_OFS_PTRS);
    end
  endfunction

  // one register's write strobe: both halves held and byte lane 0 enabled
  function wr_sel;
    input fire;
    input strb0;
    input [`DMAPF_ADDR_W-1:0] a;
    input [`DMAPF_ADDR_W-1:0] ofs;
    begin
      wr_sel = fire & strb0 & (a == ofs);
    end
  endfunction

  // word placed on the read bus for an address
  function [`DMAPF_DATA_W-1:0] rd_word;
    input [`DMAPF_ADDR_W-1:0] a;
    input [2:0] flags;
    input [2:0] mask;
    input en;
    input [`DMAPF_PTR_W-1:0] sp;
    input [`DMAPF_PTR_W-1:0] dp;
    begin
      rd_word = {`DMAPF_DATA_W{1'b0}};
      case (a)
        `DMAPF_OFS_EVENT: begin
          // upper byte and all other positions stay zero
          rd_word[`DMAPF_FLAG_HI:`DMAPF_FLAG_LO] = flags;
        end
        `DMAPF_OFS_MASK: begin
          rd_word[`DMAPF_FLAG_HI:`DMAPF_FLAG_LO] = mask;
        end
        `DMAPF_OFS_CTRL: begin
          rd_word[`DMAPF_BIT_ENABLE] = en;
        end
        `DMAPF_OFS_PTRS: begin
          rd_word = {dp, sp};
        end
        default: begin
          rd_word = {`DMAPF_DATA_W{1'b0}};
        end
      endcase
    end
  endfunction

  reg [`DMAPF_ADDR_W-1:0] aw_addr_r;
  reg aw_held_r;
  reg [`DMAPF_DATA_W-1:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_held_r;
  reg [2:0] flags_r;
  reg [2:0] flags_nxt;
  reg [2:0] mask_r;
  reg enable_r;
  wire wr_fire;
  wire lane0;
  wire [2:0] clr_bits;
  wire [2:0] set_bits;
  wire [`DMAPF_PTR_W-1:0] src_half;
  wire hit_src_done;
  wire hit_src_half;
  wire hit_dst_done;
  wire ev_wr;
  wire mask_wr;
  wire ctrl_wr;
  wire aw_fire;
  wire w_fire;
  wire b_done;
  wire ar_fire;
  wire r_done;
  reg [`DMAPF_DATA_W-1:0] rdata_nxt;
  reg [1:0] rresp_nxt;
  reg [1:0] bresp_nxt;

  // half is a plain shift; odd sizes round down
  assign src_half = source_size >> 1;

  dmapf_detect u_src_done (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .arm(enable_r),
    .ptr(source_pointer),
    .target(source_size),
    .hit_r(hit_src_done)
  );

  dmapf_detect u_src_half (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .arm(enable_r),
    .ptr(source_pointer),
    .target(src_half),
    .hit_r(hit_src_half)
  );

  dmapf_detect u_dst_done (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .arm(enable_r),
    .ptr(destination_pointer),
    .target(destination_size),
    .hit_r(hit_dst_done)
  );

  // write takes effect once both address and data are held
  assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign lane0 = w_strb_r[0];
  assign ev_wr = wr_sel(wr_fire, lane0, aw_addr_r, `DMAPF_OFS_EVENT);
  assign mask_wr = wr_sel(wr_fire, lane0, aw_addr_r, `DMAPF_OFS_MASK);
  assign ctrl_wr = wr_sel(wr_fire, lane0, aw_addr_r, `DMAPF_OFS_CTRL);

  // channel handshakes
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign b_done = s_axi_bvalid & s_axi_bready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign r_done = s_axi_rvalid & s_axi_rready;

  assign set_bits = {hit_src_done, hit_src_half, hit_dst_done};
  assign clr_bits = ev_wr ? w_data_r[`DMAPF_FLAG_HI:`DMAPF_FLAG_LO] : 3'h0;

  // a hit landing in the clearing cycle must survive, so set is or-ed last
  always @* begin
    flags_nxt = (flags_r & ~clr_bits) | set_bits;
  end

  // responses and read word worked out ahead of the handshake that loads them
  always @* begin
    bresp_nxt = mapped(aw_addr_r) ? `DMAPF_RESP_OKAY : `DMAPF_RESP_SLVERR;
    rresp_nxt = mapped(s_axi_araddr) ? `DMAPF_RESP_OKAY : `DMAPF_RESP_SLVERR;
    rdata_nxt = rd_word(s_axi_araddr, flags_r, mask_r, enable_r, source_pointer,
                        destination_pointer);
  end

  // event flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= `DMAPF_RST_FLAGS;
    end else if (aclken) begin
      flags_r <= flags_nxt;
    end
  end

  // interrupt mask, same bit layout as the event flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= `DMAPF_RST_MASK;
    end else if (aclken && mask_wr) begin
      mask_r <= w_data_r[`DMAPF_FLAG_HI:`DMAPF_FLAG_LO];
    end
  end

  // enable resets low so a stale pointer match cannot flag before setup
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= `DMAPF_RST_ENABLE;
    end else if (aclken && ctrl_wr) begin
      enable_r <= w_data_r[`DMAPF_BIT_ENABLE];
    end
  end

  // interrupt level follows unmasked flags one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else if (aclken) begin
      irq_r <= |(flags_r & mask_r);
    end
  end

  // write address: ready again only once the response has been taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= {`DMAPF_ADDR_W{1'b0}};
      aw_held_r <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (aclken) begin
      if (!aw_held_r && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (aw_fire) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (b_done) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  // write data: accepted before or after the address, held until the response
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_data_r <= {`DMAPF_DATA_W{1'b0}};
      w_strb_r <= 4'h0;
      w_held_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (aclken) begin
      if (!w_held_r && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (w_fire) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (b_done) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response: one write at a time, so no second response can queue
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DMAPF_RESP_OKAY;
    end else if (aclken) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bresp_nxt;
      end
      if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= {`DMAPF_DATA_W{1'b0}};
      s_axi_rresp <= `DMAPF_RESP_OKAY;
    end else if (aclken) begin
      if (!s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rresp_nxt;
      end
      if (r_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // dmapf_top

`default_nettype wire

// file: verif/dmapf_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dmapf_chk (
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  input wire [15:0] source_pointer,
  input wire [15:0] source_size,
  input wire [15:0] destination_pointer,
  input wire [15:0] destination_size,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire irq_r
);
  reg [7:0] ra_r;
  reg [2:0] seen_r;
  reg [2:0] wcnt_r;
  // a flag may only read high once its equality has been seen since reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      ra_r <= 8'h00;
      seen_r <= 3'h0;
      wcnt_r <= 3'h7;
    end else if (aclken) begin
      if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
      seen_r <= seen_r | {source_pointer == source_size,
        source_pointer == (source_size >> 1), destination_pointer == destination_size};
      wcnt_r <= (s_axi_wvalid && s_axi_wready) ? 3'h0 : (&wcnt_r ? wcnt_r : wcnt_r + 3'h1);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !aclken);
  sequence ev_read;
    s_axi_rvalid && ra_r == 8'h00;
  endsequence
  chk_event_upper: assert property (
    ev_read |-> s_axi_rdata[15:8] == 8'h00) else $error("event upper byte set");
  chk_src_done: assert property (
    ev_read ##0 s_axi_rdata[7] |-> seen_r[2]) else $error("source done without cause");
  chk_src_half: assert property (
    ev_read ##0 s_axi_rdata[6] |-> seen_r[1]) else $error("source half without cause");
  chk_dst_done: assert property (
    ev_read ##0 s_axi_rdata[5] |-> seen_r[0]) else $error("dest done without cause");
  chk_irq_sticky: assert property (
    $fell(irq_r) |-> wcnt_r <= 3'h4) else $error("irq dropped without a write");
endmodule // dmapf_chk
bind dmapf_top dmapf_chk i_chk (.*);
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic aclk = 0, aresetn = 0;
  // pointers start off every target so nothing fires before the checks
  logic [15:0] sp = 16'h1, ss = 16'ha, dp = 16'h1, ds = 16'h8;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] rs, rb;
  logic en = 1;
  logic [3:0] strb = 4'hf;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  dmapf_top i_dut (.aclk(aclk), .aresetn(aresetn), .aclken(en),
    .source_pointer(sp), .source_size(ss), .destination_pointer(dp),
    .destination_size(ds), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_r(irq));
  always #25 aclk = ~aclk;
  task finish_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      $display("MISMATCH %0t timeout", $time);
      finish_test;
    end
  end
  task automatic wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 0; end
    join
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    rb = bresp;
    bready <= 0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0; rready <= 1;
    do @(posedge aclk); while (!rvalid);
    d = rdata; rs = rresp; rready <= 0;
  endtask
  task automatic settle;
    repeat (5) @(posedge aclk);
  endtask
  task automatic t_reset;
    rd(8'h00); `CHK(d, 32'h0)
    `CHK(rs, 2'h0)
    rd(8'h10); `CHK(rs, 2'h2)
    `CHK(d, 32'h0)
    wr(8'h08, 32'h1); `CHK(rb, 2'h0)
    wr(8'h04, 32'he0);
    wr(8'h10, 32'hff); `CHK(rb, 2'h2)
    rd(8'h04); `CHK(d, 32'he0)
    rd(8'h08); `CHK(d, 32'h1)
    rd(8'h0c); `CHK(d, 32'h00010001)
  endtask
  task automatic t_src;
    @(posedge aclk); sp <= 16'h5; settle;
    rd(8'h00); `CHK(d, 32'h40)
    `CHK(irq, 1'b1)
    @(posedge aclk); sp <= 16'ha; settle;
    rd(8'h00); `CHK(d, 32'hc0)
  endtask
  task automatic t_dst;
    @(posedge aclk); dp <= 16'h8; settle;
    rd(8'h00); `CHK(d, 32'he0)
    wr(8'h00, 32'hffffff00);
    rd(8'h00); `CHK(d, 32'he0)
    strb <= 4'he;
    wr(8'h00, 32'he0); `CHK(rb, 2'h0)
    strb <= 4'hf;
    rd(8'h00); `CHK(d, 32'he0)
  endtask
  // pointer hit lands in the very cycle the clearing write takes effect
  task automatic t_collide;
    fork
      wr(8'h00, 32'h80);
      begin @(posedge aclk); sp <= 16'ha; end
    join
    rd(8'h00); `CHK(d, 32'h80)
    wr(8'h00, 32'h80);
    rd(8'h00); `CHK(d, 32'h0)
  endtask
  // a pointer match seen only while the clock enable is low is never sampled
  task automatic t_freeze;
    @(posedge aclk); en <= 0; sp <= 16'h5;
    settle;
    @(posedge aclk); sp <= 16'h3;
    @(posedge aclk); en <= 1;
    settle;
    rd(8'h00); `CHK(d, 32'h0)
    `CHK(irq, 1'b0)
  endtask
  task automatic t_sticky;
    @(posedge aclk); sp <= 16'h3; dp <= 16'h2; settle;
    rd(8'h00); `CHK(d, 32'he0)
    wr(8'h00, 32'h80);
    rd(8'h00); `CHK(d, 32'h60)
    wr(8'h00, 32'h60); settle;
    rd(8'h00); `CHK(d, 32'h0)
    `CHK(irq, 1'b0)
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_src;
    t_dst;
    t_sticky;
    t_collide;
    t_freeze;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
